// >>> hdl/blk_cfg_pkg.sv
// Constants for the per-block bus timing configuration logic.
// Assumes an APB slave with 32-bit data; printed offsets are register indices.
package blk_cfg_pkg;
  // Register indices, byte address is four times the index
  localparam logic [9:0] IDX_B1_HIGH = 10'h145;
  localparam logic [9:0] IDX_B2_LOW = 10'h148;
  localparam logic [9:0] IDX_B2_HIGH = 10'h149;
  localparam logic [9:0] IDX_B3_LOW = 10'h14C;
  localparam logic [9:0] IDX_B3_HIGH = 10'h14D;
  localparam logic [9:0] IDX_EX_LOW = 10'h158;
  localparam logic [9:0] IDX_EX_HIGH = 10'h159;
  localparam logic [9:0] IDX_MASK1 = 10'h146;
  localparam logic [9:0] IDX_START1 = 10'h147;
  localparam logic [9:0] IDX_STATUS = 10'h160;
  // Low register fields
  localparam int WW_LSB = 4;
  localparam int WR_LSB = 0;
  // High register fields
  localparam int EN_BIT = 7;
  localparam int AREA_BIT = 6;
  localparam int REC_BIT = 4;
  localparam int OM_LSB = 2;
  localparam int BUS_LSB = 0;
  // Reset values
  localparam logic [7:0] LOW_RST = 8'h22;
  localparam logic [7:0] HIGH_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] START_RST = 8'hFF;
  // Wait codes and bus width codes
  localparam logic [2:0] WAIT_0 = 3'h1;
  localparam logic [2:0] WAIT_1 = 3'h2;
  localparam logic [2:0] WAIT_2 = 3'h5;
  localparam logic [2:0] WAIT_3 = 3'h6;
  localparam logic [2:0] WAIT_4 = 3'h7;
  localparam logic [2:0] WAIT_PIN = 3'h3;
  localparam logic [1:0] BUS_8 = 2'h0;
  localparam logic [1:0] BUS_16 = 2'h1;
endpackage

// >>> hdl/block_bus_timing_config.sv
// Per-block external bus timing configuration for blocks 1, 2, 3 and extra.
// Assumes an APB master on clk and a CPU bus-cycle sequencer that asks for
// timing of the current access and reports its end.
// How it works
// - Write wait for blocks 2, 3 and extra from three-bit code, block 1 keeps reset code 010; 011 follows wait pin.
// - Read wait for blocks 2, 3 and extra from same encoding, block 1 keeps reset code 010; 011 follows wait pin.
// - Recovery bit set adds one dummy cycle after access; reset clear.
// - Bus width field 00 gives 8 bit, 01 gives 16 bit.
// - Block 2 bus width field has no defined reset value.
// - Address bit compared only where mask bit is 0; mask resets to 1.
`timescale 1ns/1ps
module block_bus_timing_config #(
  parameter logic [1:0] B2_BUS_STRAP = 2'h0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] cpu_addr,
  input wire logic cpu_req,
  input wire logic cpu_write,
  input wire logic access_done,
  input wire logic wait_pin,
  output logic [3:0] cs_active,
  output logic [2:0] wait_count,
  output logic wait_from_pin,
  output logic wait_reserved,
  output logic bus_16bit,
  output logic dummy_cycle
);
  ////////////////////////////////////////////////////////////////////////////
  // Index 0 = block 1, 1 = block 2, 2 = block 3, 3 = extra block
  logic [7:0] low_r [4];
  logic [7:0] high_r [4];
  logic [7:0] mask1_r;
  logic [7:0] start1_r;
  logic wait_s1_r;
  logic wait_s2_r;
  logic dummy_r;
  logic err_seen_r;
  logic [9:0] idx;
  logic wr_access;
  logic hit1;
  logic [3:0] cs_nxt;
  logic [1:0] sel;
  logic [2:0] code;

  assign idx = paddr[11:2];
  assign wr_access = psel && penable && pwrite;
  assign pready = 1'b1;

  // Strap codes 10 and 11 are reserved widths, so the decode could not serve them
  if (B2_BUS_STRAP > blk_cfg_pkg::BUS_16) begin : g_strap_check
    $error("B2_BUS_STRAP must select 8 or 16 bit width");
  end

  // Wait pin is asynchronous to clk
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_s1_r <= 1'b0;
      wait_s2_r <= 1'b0;
    end else if (clk_en) begin
      wait_s1_r <= wait_pin;
      wait_s2_r <= wait_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        low_r[i] <= blk_cfg_pkg::LOW_RST;
        high_r[i] <= blk_cfg_pkg::HIGH_RST;
      end
      mask1_r <= blk_cfg_pkg::MASK_RST;
      start1_r <= blk_cfg_pkg::START_RST;
    end else if (clk_en && wr_access) begin
      case (idx)
        blk_cfg_pkg::IDX_B1_HIGH: high_r[0] <= pwdata[7:0];
        blk_cfg_pkg::IDX_B2_LOW: low_r[1] <= pwdata[7:0];
        blk_cfg_pkg::IDX_B2_HIGH: high_r[1] <= pwdata[7:0];
        blk_cfg_pkg::IDX_B3_LOW: low_r[2] <= pwdata[7:0];
        blk_cfg_pkg::IDX_B3_HIGH: high_r[2] <= pwdata[7:0];
        blk_cfg_pkg::IDX_EX_LOW: low_r[3] <= pwdata[7:0];
        blk_cfg_pkg::IDX_EX_HIGH: high_r[3] <= pwdata[7:0];
        blk_cfg_pkg::IDX_MASK1: mask1_r <= pwdata[7:0];
        blk_cfg_pkg::IDX_START1: start1_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Block 2 width is not reset; a strap stands in for the unknown value,
  // caught by a clocked process so the reset itself loads no port.
  logic strap_done_r;
  logic [1:0] b2_bus_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_r <= 1'b0;
    end else if (clk_en) begin
      strap_done_r <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (wr_access && idx == blk_cfg_pkg::IDX_B2_HIGH) begin
        b2_bus_r <= pwdata[1:0];
      end else if (!strap_done_r) begin
        b2_bus_r <= B2_BUS_STRAP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side: control registers are write-only, status reads back
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      err_seen_r <= 1'b0;
    end else if (clk_en) begin
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        if (!pwrite && idx == blk_cfg_pkg::IDX_STATUS) begin
          prdata <= {24'h0, dummy_r, wait_s2_r, err_seen_r, 1'b0, cs_active};
        end
      end
      if (psel && penable && pwrite && !(idx inside {blk_cfg_pkg::IDX_B1_HIGH,
          blk_cfg_pkg::IDX_B2_LOW, blk_cfg_pkg::IDX_B2_HIGH, blk_cfg_pkg::IDX_B3_LOW,
          blk_cfg_pkg::IDX_B3_HIGH, blk_cfg_pkg::IDX_EX_LOW, blk_cfg_pkg::IDX_EX_HIGH,
          blk_cfg_pkg::IDX_MASK1, blk_cfg_pkg::IDX_START1})) begin
        err_seen_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Region decode; block 1 uses its mask and start registers
  always_comb begin
    hit1 = 1'b1;
    for (int b = 0; b < 8; b++) begin
      if (!mask1_r[b] && cpu_addr[16 + b] != start1_r[b]) begin
        hit1 = 1'b0;
      end
    end
  end

  // Other regions come from block-0-style decode outside; blocks 2 and 3 use
  // fixed upper ranges here, extra block catches everything else
  always_comb begin
    cs_nxt = 4'h0;
    if (cpu_req) begin
      if (hit1 && high_r[0][blk_cfg_pkg::EN_BIT]) begin
        cs_nxt[0] = 1'b1;
      end else if (cpu_addr[23:22] == 2'h2 && high_r[1][blk_cfg_pkg::EN_BIT]) begin
        cs_nxt[1] = 1'b1;
      end else if (cpu_addr[23:22] == 2'h3 && high_r[2][blk_cfg_pkg::EN_BIT]) begin
        cs_nxt[2] = 1'b1;
      end else begin
        cs_nxt[3] = 1'b1;
      end
    end
  end
  assign cs_active = cs_nxt;

  always_comb begin
    case (cs_nxt)
      4'h2: sel = 2'h1;
      4'h4: sel = 2'h2;
      4'h8: sel = 2'h3;
      default: sel = 2'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait and width for the current access
  always_comb begin
    code = cpu_write ? low_r[sel][blk_cfg_pkg::WW_LSB +: 3]
                     : low_r[sel][blk_cfg_pkg::WR_LSB +: 3];
    wait_count = 3'h0;
    wait_from_pin = 1'b0;
    wait_reserved = 1'b0;
    case (code)
      blk_cfg_pkg::WAIT_0: wait_count = 3'h0;
      blk_cfg_pkg::WAIT_1: wait_count = 3'h1;
      blk_cfg_pkg::WAIT_2: wait_count = 3'h2;
      blk_cfg_pkg::WAIT_3: wait_count = 3'h3;
      blk_cfg_pkg::WAIT_4: wait_count = 3'h4;
      blk_cfg_pkg::WAIT_PIN: wait_from_pin = wait_s2_r;
      default: wait_reserved = 1'b1;
    endcase
  end

  always_comb begin
    if (sel == 2'h1) begin
      bus_16bit = (b2_bus_r == blk_cfg_pkg::BUS_16);
    end else begin
      bus_16bit = (high_r[sel][blk_cfg_pkg::BUS_LSB +: 2] == blk_cfg_pkg::BUS_16);
    end
  end

  // Dummy cycle follows an access to a block with recovery set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dummy_r <= 1'b0;
    end else if (clk_en) begin
      dummy_r <= access_done && cpu_req && high_r[sel][blk_cfg_pkg::REC_BIT];
    end
  end
  assign dummy_cycle = dummy_r;

  ////////////////////////////////////////////////////////////////////////////
  a_dummy_follows: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && access_done && cpu_req && high_r[sel][blk_cfg_pkg::REC_BIT]
    |=> dummy_cycle) else $error("dummy cycle missing");
  a_no_dummy: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && !(access_done && cpu_req && high_r[sel][blk_cfg_pkg::REC_BIT])
    |=> !dummy_cycle) else $error("unexpected dummy cycle");
  a_cs_enable: assert property (@(posedge clk) disable iff (!resetn)
    cs_active[2] |-> high_r[2][blk_cfg_pkg::EN_BIT] && cpu_addr[23:22] == 2'h3)
    else $error("block 3 select without enable");
  a_cs_block1: assert property (@(posedge clk) disable iff (!resetn)
    cs_active[0] |-> high_r[0][blk_cfg_pkg::EN_BIT] && hit1)
    else $error("block 1 select outside region");
  a_mask_compare: assert property (@(posedge clk) disable iff (!resetn)
    cs_active[0] |-> ((cpu_addr[23:16] ^ start1_r) & ~mask1_r) == 8'h00)
    else $error("masked compare wrong");
  a_write_wait: assert property (@(posedge clk) disable iff (!resetn)
    cpu_write && low_r[sel][6:4] == 3'h6 |-> wait_count == 3'h3)
    else $error("write wait wrong");
  a_read_wait: assert property (@(posedge clk) disable iff (!resetn)
    !cpu_write && low_r[sel][2:0] == 3'h7 |-> wait_count == 3'h4)
    else $error("read wait wrong");
  a_width_16: assert property (@(posedge clk) disable iff (!resetn)
    sel == 2'h2 && high_r[2][1:0] == 2'h1 |-> bus_16bit)
    else $error("width decode wrong");
  a_b2_width: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && wr_access && idx == blk_cfg_pkg::IDX_B2_HIGH
    |=> b2_bus_r == $past(pwdata[1:0])) else $error("block 2 width lost");
endmodule

// >>> tb/ext_wait_model.sv
// External memory wait model for the chip-select blocks.
// Assumes the bench pulses go and sets the hold length in cycles.
`timescale 1ns/1ps
module ext_wait_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [3:0] hold,
  output logic wait_pin
);
  logic [3:0] cnt_r;
  // Slow device holds its wait line for hold cycles, then lets go
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
    end else if (go) begin
      cnt_r <= hold;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign wait_pin = (cnt_r != 4'h0);
endmodule

// >>> tb/block_bus_timing_config_tb.sv
// Self-checking bench for the block bus timing configuration.
// Assumes an APB master on clk and a wait model on the pin.
`timescale 1ns/1ps
module block_bus_timing_config_tb;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, cpu_req = 0, cpu_write = 0, access_done = 0;
  logic [23:0] cpu_addr = 24'hC00000;
  logic wait_pin, go = 0, wait_from_pin, wait_reserved, bus_16bit, dummy_cycle;
  logic [3:0] cs_active;
  logic [2:0] wait_count;
  logic [2:0] codes [5];
  int n_errors = 0, check_count = 0;
  always #50 clk = ~clk;
  block_bus_timing_config dut (.clk(clk), .resetn(resetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_addr(cpu_addr), .cpu_req(cpu_req),
    .cpu_write(cpu_write), .access_done(access_done), .wait_pin(wait_pin),
    .cs_active(cs_active), .wait_count(wait_count), .wait_from_pin(wait_from_pin),
    .wait_reserved(wait_reserved), .bus_16bit(bus_16bit), .dummy_cycle(dummy_cycle));
  ext_wait_model mem (.clk(clk), .resetn(resetn), .go(go), .hold(4'h6), .wait_pin(wait_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // Byte address is four times the register index
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0; penable <= 0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_waits();
    codes = '{blk_cfg_pkg::WAIT_0, blk_cfg_pkg::WAIT_1, blk_cfg_pkg::WAIT_2,
      blk_cfg_pkg::WAIT_3, blk_cfg_pkg::WAIT_4};
    @(negedge clk);
    chk(wait_count, 1);
    for (int i = 0; i < 5; i++) begin
      // Block 3 is still disabled here, so the extra block owns the access
      apb(1, blk_cfg_pkg::IDX_EX_LOW, {1'b0, codes[4-i], 1'b0, codes[i]});
      cpu_write <= 0;
      @(negedge clk);
      chk(wait_count, i);
      @(posedge clk) cpu_write <= 1;
      @(negedge clk);
      chk(wait_count, 4 - i);
    end
    apb(1, blk_cfg_pkg::IDX_EX_LOW, 8'h30);
    go <= 1;
    @(posedge clk) go <= 0;
    repeat (3) @(negedge clk);
    chk(wait_from_pin, 1);
    chk(wait_reserved, 0);
    @(posedge clk) cpu_write <= 0;
    @(negedge clk);
    chk(wait_reserved, 1);
    $display("waits done");
  endtask
  task automatic t_high();
    @(negedge clk);
    chk(dummy_cycle, 0);
    apb(1, blk_cfg_pkg::IDX_B3_HIGH, 8'h91);
    @(negedge clk);
    chk({cs_active, bus_16bit}, 5'h09);
    @(posedge clk) access_done <= 1;
    @(posedge clk) access_done <= 0;
    @(negedge clk);
    chk(dummy_cycle, 1);
    @(negedge clk);
    chk(dummy_cycle, 0);
    apb(1, blk_cfg_pkg::IDX_B3_HIGH, 8'h00);
    access_done <= 1;
    @(posedge clk) access_done <= 0;
    @(negedge clk);
    // Disabled block 3 falls through to the extra block, which has no enable
    chk({cs_active, bus_16bit, dummy_cycle}, 6'h20);
    // Width of block 2 has no reset value, so it is set before use
    apb(1, blk_cfg_pkg::IDX_B2_HIGH, 8'h81);
    cpu_addr <= 24'h800000;
    @(negedge clk);
    chk({cs_active, bus_16bit}, 5'h05);
    $display("high done");
  endtask
  task automatic t_mask();
    apb(1, blk_cfg_pkg::IDX_START1, 8'h12);
    apb(1, blk_cfg_pkg::IDX_MASK1, 8'h00);
    apb(1, blk_cfg_pkg::IDX_B1_HIGH, 8'h80);
    cpu_addr <= 24'h130000;
    @(negedge clk);
    chk(cs_active[0], 0);
    apb(1, blk_cfg_pkg::IDX_MASK1, 8'h01);
    @(negedge clk);
    chk(cs_active[0], 1);
    apb(1, 10'h3FF, 8'hAA);
    chk({pslverr, pready}, 2'h1);
    apb(0, blk_cfg_pkg::IDX_B3_LOW, 8'h00);
    chk(rd, 0);
    // Status: block 1 select in bits 3:0, unmapped write seen in bit 5
    apb(0, blk_cfg_pkg::IDX_STATUS, 8'h00);
    chk(rd, 32'h21);
    $display("mask done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1;
    cpu_req <= 1;
    t_waits();
    t_high();
    t_mask();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule
